// ===== logic/redundancy_power_control_pkg.sv
package redundancy_power_control_pkg;

    localparam int unsigned NUM_CH = 3;

    // register map: a single control register at offset zero
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    // bits 7 and 3 are read-only zero, everything else is read/write
    localparam logic [7:0] CTRL_WMASK  = 8'h77;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;

    // field positions
    localparam int unsigned TX_ON_CH0_BIT = 0;
    localparam int unsigned TX_ON_CH1_BIT = 1;
    localparam int unsigned TX_ON_CH2_BIT = 2;
    localparam int unsigned RSVD_LO_BIT   = 3;
    localparam int unsigned RX_ON_CH0_BIT = 4;
    localparam int unsigned RX_ON_CH1_BIT = 5;
    localparam int unsigned RX_ON_CH2_BIT = 6;
    localparam int unsigned RSVD_HI_BIT   = 7;

    // bit index of a channel's receive-on field
    function automatic int unsigned rxBit(input int unsigned ch);
        rxBit = RX_ON_CH0_BIT + ch;
    endfunction

    // bit index of a channel's transmit-driver-on field
    function automatic int unsigned txBit(input int unsigned ch);
        txBit = TX_ON_CH0_BIT + ch;
    endfunction

endpackage

// ===== logic/redundancy_power_control.sv
// How it works
// - bit 6 switches channel 2 receiver: 1 on, 0 off; read/write.
// - bit 5 switches channel 1 receiver: 1 on, 0 off.
// - bit 4 switches channel 0 receiver: 1 on, 0 off.
// - receiver off powers down the whole receive path, not just its outputs.
// - receiver on passes that channel's differential line input onward.
// - bit 2 enables channel 2 transmit driver: 1 drives pulses while txDriveEnablePin[2] is high, 0 off.
// - driver off tri-states both differential line output pins.
// - bit 1 enables channel 1 transmit driver; 0 tri-states its outputs.
// - bit 0 enables channel 0 transmit driver; 0 tri-states its outputs.
`timescale 1ns/1ps
module redundancy_power_control (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata_r,
    output logic            regRvalid_r,
    input  wire logic [2:0] txDriveEnablePin,
    input  wire logic [2:0] lineInPositive,
    input  wire logic [2:0] lineInNegative,
    output logic      [2:0] rxPowerOn_r,
    output logic      [2:0] rxDataPositive_r,
    output logic      [2:0] rxDataNegative_r,
    input  wire logic [2:0] txDataPositive,
    input  wire logic [2:0] txDataNegative,
    output logic      [2:0] lineOutPositive_r,
    output logic      [2:0] lineOutPositiveOe_r,
    output logic      [2:0] lineOutNegative_r,
    output logic      [2:0] lineOutNegativeOe_r
);

    ////////////////////////////////////////////////////////////////////////////
    // control register and read port

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] regRdata_nxt;
    logic       regRvalid_nxt;
    logic       ctrlHit;

    always_comb begin
        ctrlHit       = (regAddr == redundancy_power_control_pkg::CTRL_OFFSET);
        ctrl_nxt      = ctrl_r;
        regRdata_nxt  = regRdata_r;
        regRvalid_nxt = regRead;
        if (regWrite && ctrlHit) begin
            // reserved bits are masked off so they can never read back as one
            ctrl_nxt = regWdata & redundancy_power_control_pkg::CTRL_WMASK;
        end
        if (regRead) begin
            // a read in the same cycle as a write returns the old value
            regRdata_nxt = ctrlHit ? ctrl_r : redundancy_power_control_pkg::UNMAPPED_RD;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_r      <= redundancy_power_control_pkg::CTRL_RESET;
            regRdata_r  <= 8'h00;
            regRvalid_r <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            regRdata_r  <= regRdata_nxt;
            regRvalid_r <= regRvalid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel receive power and transmit driver control

    logic [2:0] rxPowerOn_nxt;
    logic [2:0] rxDataPositive_nxt;
    logic [2:0] rxDataNegative_nxt;
    logic [2:0] transmit_driver_on;
    logic [2:0] lineOutPositive_nxt;
    logic [2:0] lineOutNegative_nxt;

    always_comb begin
        for (int unsigned ch = 0; ch < redundancy_power_control_pkg::NUM_CH; ch++) begin
            // the power enable is taken straight from the register bit and also gates
            // both receive data outputs, so an off receiver passes no line input
            rxPowerOn_nxt[ch] = ctrl_r[redundancy_power_control_pkg::rxBit(ch)];
            rxDataPositive_nxt[ch] = rxPowerOn_nxt[ch] & lineInPositive[ch];
            rxDataNegative_nxt[ch] = rxPowerOn_nxt[ch] & lineInNegative[ch];
            // the external pin overrides software; low pin keeps driver off
            transmit_driver_on[ch] = ctrl_r[redundancy_power_control_pkg::txBit(ch)]
                       & txDriveEnablePin[ch];
            // data is forced low while off so a stale level never leaks out
            lineOutPositive_nxt[ch] = transmit_driver_on[ch] & txDataPositive[ch];
            lineOutNegative_nxt[ch] = transmit_driver_on[ch] & txDataNegative[ch];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxPowerOn_r         <= 3'h0;
            rxDataPositive_r    <= 3'h0;
            rxDataNegative_r    <= 3'h0;
            lineOutPositive_r   <= 3'h0;
            lineOutNegative_r   <= 3'h0;
            lineOutPositiveOe_r <= 3'h0;
            lineOutNegativeOe_r <= 3'h0;
        end else begin
            rxPowerOn_r         <= rxPowerOn_nxt;
            rxDataPositive_r    <= rxDataPositive_nxt;
            rxDataNegative_r    <= rxDataNegative_nxt;
            lineOutPositive_r   <= lineOutPositive_nxt;
            lineOutNegative_r   <= lineOutNegative_nxt;
            lineOutPositiveOe_r <= transmit_driver_on;
            lineOutNegativeOe_r <= transmit_driver_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_reserved_bits_zero: assert property (
        ctrl_r[7] == 1'b0 && ctrl_r[3] == 1'b0
        && !(regRvalid_r && (regRdata_r[7] || regRdata_r[3]))
    ) else $error("reserved control bit seen as one");

    a_write_rx_ch2: assert property (
        regWrite && regAddr == 8'h00 |=> ctrl_r[6] == $past(regWdata[6])
                                         ##1 rxPowerOn_r[2] == $past(ctrl_r[6])
    ) else $error("channel 2 receive bit not taken from write");

    a_write_rx_ch1: assert property (
        regWrite && regAddr == 8'h00 && regWdata[5] |=> ##1 rxPowerOn_r[1]
    ) else $error("channel 1 receiver did not turn on");

    a_write_rx_ch0: assert property (
        regWrite && regAddr == 8'h00 && !regWdata[4] |=> ##1 !rxPowerOn_r[0]
    ) else $error("channel 0 receiver did not shut off");

    a_rx_powered_down: assert property (
        !ctrl_r[4] |=> !rxPowerOn_r[0] && !rxDataPositive_r[0] && !rxDataNegative_r[0]
    ) else $error("channel 0 receive path active while off");

    a_rx_data_passes: assert property (
        ctrl_r[5] |=> rxDataPositive_r[1] == $past(lineInPositive[1])
                      && rxDataNegative_r[1] == $past(lineInNegative[1])
    ) else $error("channel 1 receive data not passed while on");

    a_tx_ch2_follows: assert property (
        ctrl_r[2] && txDriveEnablePin[2] |=> lineOutPositiveOe_r[2]
                                             && lineOutPositive_r[2] == $past(txDataPositive[2])
    ) else $error("channel 2 driver not driving while enabled");

    a_tx_tristate: assert property (
        !(ctrl_r[1] && txDriveEnablePin[1]) |=> !lineOutPositiveOe_r[1]
                                                && !lineOutNegativeOe_r[1]
                                                && !lineOutPositive_r[1]
    ) else $error("channel 1 outputs not tri-stated while off");

    a_tx_ch0_enable: assert property (
        lineOutNegativeOe_r[0] == ($past(ctrl_r[0]) && $past(txDriveEnablePin[0]))
    ) else $error("channel 0 driver enable mismatch");

    a_tx_ch1_enable: assert property (
        ctrl_r[1] && txDriveEnablePin[1] |=> lineOutNegativeOe_r[1]
    ) else $error("channel 1 driver not enabled");

    a_tx_ch1_negative: assert property (
        ctrl_r[1] && txDriveEnablePin[1] |=> lineOutNegative_r[1] == $past(txDataNegative[1])
    ) else $error("channel 1 negative output not following data");

    // a read answers one cycle later with the value held before any same-cycle write
    a_read_ctrl_value: assert property (
        regRead && regAddr == redundancy_power_control_pkg::CTRL_OFFSET
            |=> regRvalid_r && regRdata_r == $past(ctrl_r)
    ) else $error("control read did not return the register value");

    // only a write to the control offset may move the register
    a_ctrl_holds: assert property (
        !(regWrite && regAddr == redundancy_power_control_pkg::CTRL_OFFSET)
            |=> ctrl_r == $past(ctrl_r)
    ) else $error("control register changed without a write");

    a_rx_ch1_off: assert property (
        regWrite && regAddr == redundancy_power_control_pkg::CTRL_OFFSET && !regWdata[5]
            |=> ##1 !rxPowerOn_r[1] && !rxDataPositive_r[1]
    ) else $error("channel 1 receiver did not shut off");

    a_rx_ch2_data_gated: assert property (
        !ctrl_r[6] |=> !rxPowerOn_r[2] && !rxDataPositive_r[2] && !rxDataNegative_r[2]
    ) else $error("channel 2 receive data active while off");

    a_rx_ch0_data_passes: assert property (
        ctrl_r[4] |=> rxDataNegative_r[0] == $past(lineInNegative[0])
    ) else $error("channel 0 receive data not passed while on");

    a_tx_ch2_negative: assert property (
        ctrl_r[2] && txDriveEnablePin[2] |=> lineOutNegativeOe_r[2]
            && lineOutNegative_r[2] == $past(txDataNegative[2])
    ) else $error("channel 2 negative output not driving while enabled");

    // a low enable pin must win over a set register bit
    a_pin_forces_off: assert property (
        !txDriveEnablePin[0] |=> !lineOutPositiveOe_r[0] && !lineOutPositive_r[0]
    ) else $error("channel 0 driver on while its enable pin is low");

    a_tx_ch0_tristate: assert property (
        !ctrl_r[0] |=> !lineOutPositiveOe_r[0] && !lineOutNegativeOe_r[0]
            && !lineOutNegative_r[0]
    ) else $error("channel 0 outputs not tri-stated while off");

    a_reset_all_off: assert property (@(posedge clock) disable iff (1'b0)
        !rstn |-> ctrl_r == 8'h00 && rxPowerOn_r == 3'h0 && lineOutPositiveOe_r == 3'h0
    ) else $error("control not cleared during reset");

    c_rx_all_on:  cover property (rxPowerOn_r == 3'h7);
    c_tx_driving: cover property (lineOutPositiveOe_r[2] ##1 !lineOutPositiveOe_r[2]);
    c_pin_blocks: cover property (ctrl_r[0] && !txDriveEnablePin[0]);
    c_read_back:  cover property (regRvalid_r && regRdata_r != 8'h00);

endmodule

// ===== verif/redundancy_power_control_bench.sv
`timescale 1ns/1ps
module redundancy_power_control_bench;
    logic       clock            = 1'b0;
    logic       rstn             = 1'b1;
    logic [7:0] regAddr          = 8'h00;
    logic       regWrite         = 1'b0;
    logic       regRead          = 1'b0;
    logic [7:0] regWdata         = 8'h00;
    logic [2:0] txDriveEnablePin = 3'h0;
    logic [2:0] lineInPositive   = 3'h0;
    logic [2:0] lineInNegative   = 3'h0;
    logic [2:0] txDataPositive   = 3'h0;
    logic [2:0] txDataNegative   = 3'h0;
    logic [7:0] regRdata_r;
    logic       regRvalid_r;
    logic [2:0] rxPowerOn_r, rxDataPositive_r, rxDataNegative_r;
    logic [2:0] lineOutPositive_r, lineOutPositiveOe_r, lineOutNegative_r, lineOutNegativeOe_r;
    int         err_total        = 0;
    int         num_checks       = 0;
    logic [7:0] v;
    redundancy_power_control uut (.clock(clock), .rstn(rstn), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata_r(regRdata_r),
        .regRvalid_r(regRvalid_r), .txDriveEnablePin(txDriveEnablePin),
        .lineInPositive(lineInPositive), .lineInNegative(lineInNegative),
        .rxPowerOn_r(rxPowerOn_r), .rxDataPositive_r(rxDataPositive_r),
        .rxDataNegative_r(rxDataNegative_r), .txDataPositive(txDataPositive),
        .txDataNegative(txDataNegative), .lineOutPositive_r(lineOutPositive_r),
        .lineOutPositiveOe_r(lineOutPositiveOe_r), .lineOutNegative_r(lineOutNegative_r),
        .lineOutNegativeOe_r(lineOutNegativeOe_r));
    always #12.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    // inputs always move 2 ns after the rising edge, clear of the sampling point
    task automatic tick();
        @(posedge clock);
        #2;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a; regWdata = d; regWrite = 1'b1;
        tick();
        regWrite = 1'b0;
        tick();
    endtask
    // the answer is registered on the strobe edge; regRvalid_r drops at the next edge, regRdata_r holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        regAddr = a; regRead = 1'b1;
        tick();
        chk({7'h00, regRvalid_r}, 8'h01);
        d = regRdata_r;
        regRead = 1'b0;
        tick();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        rd(8'h00, v);
        chk(v, 8'h00);
        chk({5'h00, rxPowerOn_r | lineOutPositiveOe_r | lineOutNegativeOe_r}, 8'h00);
        $display("test reset done");
    endtask
    // walking one through all eight bits: reserved bits drop, rx enables follow
    task automatic test_bits();
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, 8'h01 << i);
            rd(8'h00, v);
            chk(v, (8'h01 << i) & 8'h77);
            chk({5'h00, rxPowerOn_r}, {5'h00, v[6:4]});
        end
        $display("test bits done");
    endtask
    task automatic test_rx();
        wr(8'h00, 8'h50);
        lineInPositive = 3'h7; lineInNegative = 3'h5;
        tick(); tick();
        chk({5'h00, rxDataPositive_r}, 8'h05);
        chk({5'h00, rxDataNegative_r}, 8'h05);
        wr(8'h00, 8'h20);
        lineInPositive = 3'h2; lineInNegative = 3'h3;
        tick(); tick();
        chk({5'h00, rxDataPositive_r}, 8'h02);
        chk({5'h00, rxDataNegative_r}, 8'h02);
        chk({5'h00, rxPowerOn_r}, 8'h02);
        $display("test rx done");
    endtask
    // a low enable pin must override a set register bit
    task automatic test_tx();
        wr(8'h00, 8'h07);
        txDriveEnablePin = 3'h5; txDataPositive = 3'h7; txDataNegative = 3'h3;
        tick(); tick();
        chk({5'h00, lineOutPositiveOe_r}, 8'h05);
        chk({5'h00, lineOutNegativeOe_r}, 8'h05);
        chk({5'h00, lineOutPositive_r}, 8'h05);
        chk({5'h00, lineOutNegative_r}, 8'h01);
        wr(8'h00, 8'h02);
        txDriveEnablePin = 3'h7;
        tick(); tick();
        chk({5'h00, lineOutPositiveOe_r & lineOutNegativeOe_r}, 8'h02);
        chk({5'h00, lineOutPositive_r | lineOutNegative_r}, 8'h02);
        $display("test tx done");
    endtask
    task automatic test_unmapped();
        wr(8'h01, 8'h00);
        rd(8'h01, v);
        chk(v, 8'h00);
        rd(8'h00, v);
        chk(v, 8'h02);
        $display("test unmapped done");
    endtask
    // reset in mid-run must clear a live configuration at once
    task automatic test_midreset();
        txDriveEnablePin = 3'h6;
        wr(8'h00, 8'h77);
        tick();
        chk({5'h00, lineOutPositiveOe_r}, 8'h06);
        rstn = 1'b0;
        #1;
        chk({5'h00, rxPowerOn_r | lineOutPositiveOe_r | lineOutNegativeOe_r}, 8'h00);
        repeat (2) tick();
        rstn = 1'b1;
        rd(8'h00, v);
        chk(v, 8'h00);
        $display("test midreset done");
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        // a real falling edge, so the asynchronous clear acts before the first clock edge
        #1 rstn = 1'b0;
        repeat (5) @(posedge clock);
        #2 rstn = 1'b1;
        test_reset();
        test_bits();
        test_rx();
        test_tx();
        test_unmapped();
        test_midreset();
        give_verdict();
    end
endmodule
